//--- rtl/tccu_pkg.sv
package tccu_pkg;
	// Register byte addresses on APB
	localparam logic [11:0] ADDR_CAP_LOW = 12'h000;
	localparam logic [11:0] ADDR_CAP_HIGH = 12'h004;
	localparam logic [11:0] ADDR_UNIT_CONTROL = 12'h008;
	localparam logic [11:0] ADDR_FLAGS = 12'h00c;
	localparam logic [11:0] ADDR_TIME_BASE = 12'h010;
	localparam logic [11:0] ADDR_CAN_CTRL = 12'h014;
	// Field positions and masks
	localparam int FLAG_BIT = 0;
	localparam int SEL_LOW_BIT = 0;
	localparam int SEL_HIGH_BIT = 1;
	localparam int CAN_CAP_BIT = 0;
	localparam logic [7:0] CONTROL_WMASK = 8'h3f;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// Mode codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_CAN = 4'h3;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
	// Prescaler terminal counts
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tccu_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tccu_apb_rsp_t;

	typedef struct packed {
		logic first_reset;
		logic third_reset;
	} tccu_timer_reset_t;
endpackage

//--- rtl/tccu_top.sv
`timescale 1ns/1ps
//
// Contract
// - Capture copies the selected 16-bit timer count into the capture pair.
// - Mode picks falling, rising, every 4th or 16th rising edge.
// - Each capture sets the flag; it stays until software clears it.
// - A new capture overwrites the pair even if unread.
// - Pin should be input; edges from port writes still capture.
// - Time base is first or third timer by select bits.
// - Prescaler clears when off, not in capture, or reset.
// - Switching prescaler settings keeps the count; may set flag.
// - CAN receiver gives a rising edge on message received.
// - CAN capture enable replaces the pin by message-received event.
// - Compare matches register to timer; pin high, low, toggle, none.
// - Each compare match sets the flag with the pin action.
// - Clearing control forces the compare output latch low.
// - Software-interrupt compare mode leaves pin, only sets flag.
// - Special trigger match pulses reset of the time-base timer.
// - Trigger reset does not set the timer overflow flag.
// - Companion unit may use its own time base independently.
// - Mode codes 0000 off, 0011 CAN, 0100-0111 captures.
// - Compare codes 0010, 1000, 1001, 1010, 1011.
// - Select 1x third both, 01 split, 00 first both.
module tccu_top
	import tccu_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	input wire tccu_pkg::tccu_apb_req_t apb_req_in,
	output tccu_pkg::tccu_apb_rsp_t apb_rsp_out,
	input wire logic [15:0] first_timer_count_in,
	input wire logic [15:0] third_timer_count_in,
	input wire logic pin_in,
	input wire logic can_msg_received_in,
	output logic pin_out,
	output tccu_pkg::tccu_timer_reset_t timer_reset_out,
	output logic companion_uses_third_out,
	output logic unit_interrupt_flag_out
);
	import tccu_pkg::*;

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	logic [7:0] unit_control;
	logic [7:0] capture_compare_low_byte;
	logic [7:0] capture_compare_high_byte;
	logic unit_interrupt_flag;
	logic time_base_select_high;
	logic time_base_select_low;
	logic can_capture_enable;
	logic [3:0] prescale_count;
	logic compare_latch;
	logic [3:0] prev_mode;

	// ---------------------------------------------
	// Input synchronisers
	// ---------------------------------------------
	logic pin_meta;
	logic pin_sync;
	logic pin_last;
	logic can_meta;
	logic can_sync;
	logic can_last;

	// Only the second and third flops feed edge logic, the first may be metastable
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_last <= 1'b0;
		end
		else if (clk_en_in)
		begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			can_meta <= 1'b0;
			can_sync <= 1'b0;
			can_last <= 1'b0;
		end
		else if (clk_en_in)
		begin
			can_meta <= can_msg_received_in;
			can_sync <= can_meta;
			can_last <= can_sync;
		end
	end

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	function automatic logic is_capture(input logic [3:0] m);
		return (m == MODE_CAP_CAN) || (m[3:2] == 2'b01);
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		return (m == MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
	endfunction

	wire [3:0] mode = unit_control[3:0];
	wire cap_mode = is_capture(mode);
	wire cmp_mode = is_compare(mode);
	// this unit uses third timer only when select is 1x
	wire use_third = time_base_select_high;
	wire [15:0] time_base = use_third ? third_timer_count_in
		: first_timer_count_in;
	wire pin_rise = pin_sync & ~pin_last;
	wire pin_fall = ~pin_sync & pin_last;
	wire can_rise = can_sync & ~can_last;
	// CAN event replaces pin whenever enable is set
	wire rise_src = can_capture_enable ? can_rise : pin_rise;
	wire fall_src = can_capture_enable ? 1'b0 : pin_fall;
	// Edges from a driven pin come back through pin_in, so they count
	wire prescale_step = rise_src &&
		(mode == MODE_CAP_RISE4 || mode == MODE_CAP_RISE16);
	wire prescale_last = (mode == MODE_CAP_RISE4)
		? (prescale_count[1:0] == PRESCALE_4_LAST[1:0])
		: (prescale_count == PRESCALE_16_LAST);
	wire cap_event =
		(mode == MODE_CAP_FALL && fall_src) ||
		(mode == MODE_CAP_RISE && rise_src) ||
		(mode == MODE_CAP_CAN && rise_src) ||
		(prescale_step && prescale_last);
	wire cmp_match = cmp_mode &&
		(time_base == {capture_compare_high_byte,
		capture_compare_low_byte});
	// Match is level; raise actions only on its first cycle
	logic match_last;
	wire match_event = cmp_match & ~match_last;

	// ---------------------------------------------
	// APB slave
	// ---------------------------------------------
	wire bus_access = apb_req_in.psel & apb_req_in.penable;
	wire bus_write = bus_access & apb_req_in.pwrite;
	wire hit_low = apb_req_in.paddr == ADDR_CAP_LOW;
	wire hit_high = apb_req_in.paddr == ADDR_CAP_HIGH;
	wire hit_ctrl = apb_req_in.paddr == ADDR_UNIT_CONTROL;
	wire hit_flag = apb_req_in.paddr == ADDR_FLAGS;
	wire hit_tb = apb_req_in.paddr == ADDR_TIME_BASE;
	wire hit_can = apb_req_in.paddr == ADDR_CAN_CTRL;
	wire hit_any = hit_low | hit_high | hit_ctrl | hit_flag |
		hit_tb | hit_can;
	logic [7:0] read_byte;

	always_comb
	begin
		read_byte = 8'h00;
		if (hit_low)
			read_byte = capture_compare_low_byte;
		else if (hit_high)
			read_byte = capture_compare_high_byte;
		else if (hit_ctrl)
			read_byte = unit_control;
		else if (hit_flag)
			read_byte = {7'h00, unit_interrupt_flag};
		else if (hit_tb)
			read_byte = {6'h00, time_base_select_high,
				time_base_select_low};
		else if (hit_can)
			read_byte = {7'h00, can_capture_enable};
	end

	wire [7:0] wbyte = apb_req_in.pwdata[7:0];
	wire ctrl_write = bus_write & apb_rsp_out.pready & hit_ctrl;
	wire [7:0] next_control = wbyte & CONTROL_WMASK;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			apb_rsp_out <= '0;
		else if (clk_en_in)
		begin
			apb_rsp_out.pready <= apb_req_in.psel & ~apb_req_in.penable
				& ~apb_rsp_out.pready;
			apb_rsp_out.pslverr <= apb_req_in.psel & ~apb_req_in.penable
				& ~hit_any;
			apb_rsp_out.prdata <= {24'h000000, read_byte};
		end
	end

	// Access phase ends on the cycle pready is high
	wire bus_done = bus_access & apb_rsp_out.pready;

	// ---------------------------------------------
	// Control and time-base select
	// ---------------------------------------------
	wire tb_write = bus_done & apb_req_in.pwrite & hit_tb;
	wire can_write = bus_done & apb_req_in.pwrite & hit_can;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			unit_control <= CONTROL_RESET;
		else if (clk_en_in && ctrl_write)
			unit_control <= next_control;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			time_base_select_high <= 1'b0;
			time_base_select_low <= 1'b0;
		end
		else if (clk_en_in && tb_write)
		begin
			time_base_select_high <= wbyte[SEL_HIGH_BIT];
			time_base_select_low <= wbyte[SEL_LOW_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			can_capture_enable <= 1'b0;
		else if (clk_en_in && can_write)
			can_capture_enable <= wbyte[CAN_CAP_BIT];
	end

	// Mode and match history for entry and edge detection
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			prev_mode <= MODE_OFF;
			match_last <= 1'b0;
		end
		else if (clk_en_in)
		begin
			prev_mode <= mode;
			match_last <= cmp_match;
		end
	end

	// ---------------------------------------------
	// Prescaler
	// ---------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			prescale_count <= 4'h0;
		else if (clk_en_in)
		begin
			// Kept across direct prescale switches, so first may be early
			if (!cap_mode)
				prescale_count <= 4'h0;
			else if (prescale_step)
				prescale_count <= prescale_last ? 4'h0
					: prescale_count + 4'h1;
		end
	end

	// ---------------------------------------------
	// Capture/compare pair and flag
	// ---------------------------------------------
	// Hardware set wins over software clear in the same cycle
	wire flag_set = (cap_mode && cap_event) ||
		match_event;
	wire flag_clear = bus_done & apb_req_in.pwrite & hit_flag
		& wbyte[FLAG_BIT];

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			capture_compare_low_byte <= 8'h00;
			capture_compare_high_byte <= 8'h00;
		end
		else if (clk_en_in)
		begin
			if (cap_mode && cap_event)
			begin
				capture_compare_low_byte <= time_base[7:0];
				capture_compare_high_byte <= time_base[15:8];
			end
			else if (bus_done && apb_req_in.pwrite)
			begin
				if (hit_low)
					capture_compare_low_byte <= wbyte;
				if (hit_high)
					capture_compare_high_byte <= wbyte;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			unit_interrupt_flag <= 1'b0;
		else if (clk_en_in && flag_set)
			unit_interrupt_flag <= 1'b1;
		else if (clk_en_in && flag_clear)
			unit_interrupt_flag <= 1'b0;
	end

	// ---------------------------------------------
	// Compare output latch and trigger
	// ---------------------------------------------
	wire mode_entered = mode != prev_mode;
	wire trig_now = match_event && mode == MODE_CMP_TRIG;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			compare_latch <= 1'b0;
		else if (clk_en_in)
		begin
			if (mode == MODE_OFF)
				compare_latch <= 1'b0;
			else if (mode_entered && mode == MODE_CMP_SET)
				compare_latch <= 1'b0;
			else if (mode_entered && mode == MODE_CMP_CLEAR)
				compare_latch <= 1'b1;
			else if (match_event)
			begin
				if (mode == MODE_CMP_SET)
					compare_latch <= 1'b1;
				else if (mode == MODE_CMP_CLEAR)
					compare_latch <= 1'b0;
				else if (mode == MODE_CMP_TOGGLE)
					compare_latch <= ~compare_latch;
			end
		end
	end

	// Trigger is a reset only; overflow flags stay untouched
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			timer_reset_out <= '0;
		else if (clk_en_in)
		begin
			timer_reset_out.first_reset <= trig_now & ~use_third;
			timer_reset_out.third_reset <= trig_now & use_third;
		end
	end

	// Companion gets third unless select is 00
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			companion_uses_third_out <= 1'b0;
		else if (clk_en_in)
			companion_uses_third_out <= time_base_select_high
				| time_base_select_low;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			unit_interrupt_flag_out <= 1'b0;
		else if (clk_en_in)
			unit_interrupt_flag_out <= unit_interrupt_flag;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pin_out <= 1'b0;
		else if (clk_en_in)
			pin_out <= compare_latch;
	end
endmodule // tccu_top

//--- tb/tccu_timers.sv
`timescale 1ns/1ps
// ------------------------------
// Timer pair seen by the unit
// ------------------------------
module tccu_timers
	import tccu_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic run_in,
	input wire logic load_in,
	input wire logic [15:0] load_val_in,
	input wire tccu_pkg::tccu_timer_reset_t clear_in,
	output logic [15:0] first_out,
	output logic [15:0] third_out
);
	// Clocked timer mode only, async counting is not modelled
	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
			{first_out, third_out} <= 32'h0;
		else if (load_in)
			{first_out, third_out} <= {load_val_in, load_val_in + 16'h0100};
		else
		begin
			// Trigger clears only the timer whose reset bit is set and raises no overflow
			first_out <= clear_in.first_reset ? 16'h0 : first_out + 16'(run_in);
			third_out <= clear_in.third_reset ? 16'h0 : third_out + 16'(run_in);
		end
endmodule // tccu_timers

//--- tb/tccu_top_asserts.sv
`timescale 1ns/1ps
module tccu_top_asserts
	import tccu_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire tccu_pkg::tccu_apb_req_t apb_req_in,
	input wire tccu_pkg::tccu_apb_rsp_t apb_rsp_out,
	input wire logic pin_out,
	input wire tccu_pkg::tccu_timer_reset_t timer_reset_out,
	input wire logic companion_uses_third_out,
	input wire logic unit_interrupt_flag_out
);
	// ------------------------------
	// Shadow of the writes that matter
	// ------------------------------
	logic wr, clr, off_q;
	logic [1:0] sel_q;
	tccu_timer_reset_t tr;
	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	assign tr = timer_reset_out;
	assign wr = apb_req_in.penable && apb_req_in.pwrite && apb_rsp_out.pready;
	assign clr = wr && apb_req_in.paddr == ADDR_FLAGS
		&& apb_req_in.pwdata[0];
	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
			{off_q, sel_q} <= 3'h4;
		else if (wr && apb_req_in.paddr == ADDR_UNIT_CONTROL)
			off_q <= apb_req_in.pwdata[3:0] == MODE_OFF;
		else if (wr && apb_req_in.paddr == ADDR_TIME_BASE)
			sel_q <= apb_req_in.pwdata[1:0];
	chk_apb_answer: assert property (apb_req_in.psel && !apb_req_in.penable
		|=> apb_rsp_out.pready) else $error("no pready after setup");
	chk_ready_pulse: assert property (apb_rsp_out.pready
		|=> !apb_rsp_out.pready) else $error("pready held");
	chk_bad_addr: assert property (apb_rsp_out.pready
		&& apb_req_in.paddr > ADDR_CAN_CTRL |-> apb_rsp_out.pslverr)
		else $error("no error on unmapped address");
	chk_flag_hold: assert property ($fell(unit_interrupt_flag_out)
		|-> $past(clr, 2)) else $error("flag fell without clear");
	chk_trig_flag: assert property (tr != 2'b00
		|=> unit_interrupt_flag_out) else $error("trigger without flag");
	chk_trig_base: assert property (tr != 2'b00
		|-> tr == {~sel_q[1], sel_q[1]}) else $error("wrong timer reset");
	chk_trig_pulse: assert property (tr != 2'b00
		|=> tr == 2'b00) else $error("trigger too long");
	chk_off_low: assert property (off_q |-> ##2 !pin_out)
		else $error("pin high while unit off");
	chk_companion_base: assert property (wr
		&& apb_req_in.paddr == ADDR_TIME_BASE
		|=> ##1 companion_uses_third_out == (sel_q != 2'b00))
		else $error("companion time base wrong");
	cover property (tr.third_reset);
	cover property (clr);
	cover property ($rose(pin_out));
endmodule // tccu_top_asserts

bind tccu_top tccu_top_asserts tccu_top_asserts_inst (.*);

//--- tb/timer_capture_compare_unit_test.sv
`timescale 1ns/1ps
module timer_capture_compare_unit_test;
	import tccu_pkg::*;
	// ------------------------------
	// Register rows: address, write, read back
	// ------------------------------
	logic [11:0] ra [7] = '{ADDR_CAP_LOW, ADDR_CAP_HIGH, ADDR_UNIT_CONTROL,
		ADDR_FLAGS, ADDR_TIME_BASE, ADDR_CAN_CTRL, 12'h018};
	logic [7:0] rw [7] = '{8'ha5, 8'h5a, 8'hf0, 8'h01, 8'h03, 8'h01, 8'h77};
	logic [7:0] rx [7] = '{8'ha5, 8'h5a, 8'h30, 8'h00, 8'h03, 8'h01, 8'h00};
	logic [3:0] caps [5] = '{MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_RISE4,
		MODE_CAP_RISE16, MODE_CAP_CAN};
	// Mode, select, pin on entry, pin after match
	logic [7:0] cmps [6] = '{8'h81, 8'h96, 8'h21, 8'hac, 8'hb0, 8'hb8};
	logic clk, arst_n, pin, can, pin_o, comp, flag, run, load, err, pi, pf, c;
	logic [15:0] lval, first, third, b;
	logic [31:0] rd;
	logic [3:0] m;
	logic [1:0] s;
	tccu_apb_req_t req;
	tccu_apb_rsp_t rsp;
	tccu_timer_reset_t trst;
	int n_fail, tests_run, i, k, n;
	tccu_top tccu_top_inst (.clk_in(clk), .arst_n_in(arst_n), .clk_en_in(1'b1),
		.apb_req_in(req), .apb_rsp_out(rsp), .first_timer_count_in(first),
		.third_timer_count_in(third), .pin_in(pin), .can_msg_received_in(can),
		.pin_out(pin_o), .timer_reset_out(trst),
		.companion_uses_third_out(comp), .unit_interrupt_flag_out(flag));
	tccu_timers tccu_timers_inst (.clk_in(clk), .arst_n_in(arst_n),
		.run_in(run), .load_in(load), .load_val_in(lval), .clear_in(trst),
		.first_out(first), .third_out(third));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bail;
		n_fail++;
		final_report;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int j;
		req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		@(posedge clk);
		req.penable <= 1'b1;
		// Pready is taken at the rising edge that ends the access
		j = 0;
		do
		begin
			@(posedge clk);
			j++;
		end
		while (j < 20 && rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge clk);
		if (j == 20)
			bail;
	endtask
	task automatic pulse(input int cnt, input logic on_can);
		repeat (cnt)
		begin
			{can, pin} <= on_can ? 2'b10 : 2'b01;
			cyc(4);
			{can, pin} <= 2'b00;
			cyc(4);
		end
	endtask
	task automatic loadv(input logic [15:0] v);
		{load, lval} <= {1'b1, v};
		cyc(1);
		load <= 1'b0;
	endtask
	initial
	begin
		{arst_n, pin, can, run, load} = 5'h0;
		req = '0;
		lval = 16'h0;
		cyc(2);
		arst_n <= 1'b1;
		cyc(1);
		for (k = 0; k < 7; k++)
		begin
			apb(1'b1, ra[k], rw[k]);
			apb(1'b0, ra[k], 8'h00);
			check("readback", rx[k], rd);
			check("slave error", k == 6, err);
		end
		$display("test registers done");
		for (k = 0; k < 5; k++)
		begin
			m = caps[k];
			s = k[1:0];
			c = m == MODE_CAP_CAN;
			n = m == MODE_CAP_RISE4 ? 4 : m == MODE_CAP_RISE16 ? 16 : 1;
			apb(1'b1, ADDR_UNIT_CONTROL, 8'h00);
			apb(1'b1, ADDR_CAN_CTRL, {7'h0, c});
			apb(1'b1, ADDR_TIME_BASE, {6'h0, s});
			apb(1'b1, ADDR_UNIT_CONTROL, {4'h0, m});
			apb(1'b1, ADDR_FLAGS, 8'h01);
			check("companion", s != 2'b00, comp);
			loadv(16'h1230 + 16'(k));
			pulse(n - 1, c);
			pulse(1, !c);
			apb(1'b0, ADDR_FLAGS, 8'h00);
			check("early flag", 0, rd);
			pulse(1, c);
			apb(1'b0, ADDR_FLAGS, 8'h00);
			check("capture flag", 1, rd);
			loadv(16'h4560 + 16'(k));
			pulse(n, c);
			b = 16'h4560 + 16'(k) + (s[1] ? 16'h0100 : 16'h0000);
			apb(1'b0, ADDR_CAP_LOW, 8'h00);
			check("capture low", b[7:0], rd);
			apb(1'b0, ADDR_CAP_HIGH, 8'h00);
			check("capture high", b[15:8], rd);
		end
		$display("test captures done");
		for (k = 0; k < 6; k++)
		begin
			{m, s, pi, pf} = cmps[k];
			b = s[1] ? 16'h0100 : 16'h0000;
			apb(1'b1, ADDR_UNIT_CONTROL, 8'h00);
			cyc(2);
			check("pin off", 0, pin_o);
			apb(1'b1, ADDR_TIME_BASE, {6'h0, s});
			loadv(16'h0000);
			apb(1'b1, ADDR_CAP_LOW, 8'h10);
			apb(1'b1, ADDR_CAP_HIGH, b[15:8]);
			apb(1'b1, ADDR_UNIT_CONTROL, {4'h0, m});
			apb(1'b1, ADDR_FLAGS, 8'h01);
			cyc(2);
			check("pin on entry", pi, pin_o);
			run <= 1'b1;
			for (i = 0; i < 64 && flag !== 1'b1; i++)
				cyc(1);
			run <= 1'b0;
			if (i == 64)
				bail;
			cyc(3);
			check("pin after match", pf, pin_o);
			b = b + 16'h0010;
			b = (s[1] ? third : first) < b;
			check("restart", m == MODE_CMP_TRIG, b);
		end
		$display("test compares done");
		apb(1'b1, ADDR_UNIT_CONTROL, {4'h0, MODE_CMP_CLEAR});
		arst_n <= 1'b0;
		cyc(2);
		check("outputs in reset", 0, {pin_o, trst, comp, flag});
		arst_n <= 1'b1;
		cyc(1);
		apb(1'b0, ADDR_UNIT_CONTROL, 8'h00);
		check("control after reset", 0, rd);
		$display("test reset done");
		final_report;
	end
endmodule // timer_capture_compare_unit_test
